// ---- core/slcd_regs.vh ----
/*
  Constants of the segment LCD driver: control register layout, display
  buffer window, drive level codes, duty codes and clock tap positions.
  Assumes the block clock is the high-frequency clock at 10 MHz.
*/
// Overview of operation
// (R1) Control bit picks internal booster (1) or external resistor divider (0).
// (R2) Two-bit boost clock field picks booster clock tap from main or sub clock.
// (R3) Software keeps duty codes 10 and 11 unused while the booster is selected.
// (R4) Display pattern lives in 16 bytes at 0F80H..0F8FH, written as memory.
// (R5) Hardware fetches the buffer itself; a CPU write alone changes the display.
// (R6) Buffer bit one lights its pixel; zero leaves it dark.
// (R7) Upper nibble odd segment, lower nibble even; bit n maps to common n.
// (R8) Duty sets how many nibble bits are used; unused bits are free data.
// (R9) Display enable zero blanks: all segment and common lines at ground.
// (R10) Stop mode entry clears display enable; software sets it again after.
// (R11) During reset lines are low and shared port pins are high impedance.
// (R12) Software initialises the whole buffer before enabling the display.
// (R13) Control register resets to zero: enable, booster, boost clk, duty, frame.
// (R14) Software avoids boost clock code 11 in slow operating modes.
// (R15) Fetch yields to CPU writes; a torn update lasts at most one frame.
`ifndef SLCD_REGS_VH
`define SLCD_REGS_VH

// Control register
`define SLCD_CTRL_RESET    8'h00
`define SLCD_EN_BIT        7
`define SLCD_VOLTAGE_SOURCE_SELECT_BIT      6
`define SLCD_VF_HI         5
`define SLCD_VF_LO         4
`define SLCD_DUTY_HI       3
`define SLCD_DUTY_LO       2
`define SLCD_SLF_HI        1
`define SLCD_SLF_LO        0

// Display buffer window
`define SLCD_BUF_BASE      8'hf8
`define SLCD_BUF_DEPTH     16
`define SLCD_BUF_LAST      4'hf

// Drive duty codes
`define SLCD_DUTY_QUARTER  2'h0
`define SLCD_DUTY_THIRD    2'h1
`define SLCD_DUTY_HALF     2'h2
`define SLCD_DUTY_STATIC   2'h3

// Drive level codes on each line
`define SLCD_LV_GND        2'h0
`define SLCD_LV_V1         2'h1
`define SLCD_LV_V2         2'h2
`define SLCD_LV_V3         2'h3

// Prescaler widths; tap k toggles at clock/2^(k+1)
`define SLCD_FC_W          14
`define SLCD_FS_W          6
// Boost taps: fc/2^13, fc/2^11, fc/2^10, fc/2^9 and fs/2^5, fs/2^3, fs/2^2
`define SLCD_BST_FC0       12
`define SLCD_BST_FC1       10
`define SLCD_BST_FC2       9
`define SLCD_BST_FC3       8
`define SLCD_BST_FS0       4
`define SLCD_BST_FS1       2
`define SLCD_BST_FS2       1
// Half-slot taps at eight times the frame base: fc/2^17,16,15,13 and fs/2^9,8
`define SLCD_HS_FC0        13
`define SLCD_HS_FC1        12
`define SLCD_HS_FC2        11
`define SLCD_HS_FC3        9
`define SLCD_HS_FS0        5
`define SLCD_HS_FS1        4
// Static drive stretches each half slot by this many taps
`define SLCD_STATIC_STRETCH 2'h3

`endif

// ---- core/slcd_driver.v ----
/*
  Segment LCD driver: control register, 16-byte display buffer, buffer
  fetch into a frame snapshot, prescalers for booster and frame timing,
  and 32 segment plus 4 common drive level codes.
  Assumes CPU strobes are synchronous to clk; sub_clk is a free pin.
*/
`include "slcd_regs.vh"

module slcd_driver (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Control register access
  input  wire        ctrl_wr,
  input  wire [7:0]  ctrl_wdata,
  output wire [7:0]  lcd_control_reg,
  // Shared data buffer access
  input  wire        mem_wr,
  input  wire [11:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  output reg  [7:0]  mem_rdata,
  output wire        mem_hit,
  // System state
  input  wire        stop_enter,
  input  wire        use_sub_clock,
  input  wire        sub_clk,
  input  wire [31:0] seg_pin_select,
  // Booster
  output reg         booster_on,
  output reg         boost_clk,
  // Panel lines
  output reg  [63:0] segment_line,
  output reg  [7:0]  common_line,
  output reg  [31:0] segment_line_oe
);

  reg  [7:0]  shared_data_buffer [0:`SLCD_BUF_DEPTH-1];
  reg  [7:0]  frame_snap         [0:`SLCD_BUF_DEPTH-1];
  reg         display_enable_bit;
  reg         voltage_source_select;
  reg  [1:0]  boost_clock_select;
  reg  [1:0]  duty_r;
  reg  [1:0]  frame_rate_select;
  reg  [`SLCD_FC_W-1:0] fc_cnt_r;
  reg  [`SLCD_FS_W-1:0] fs_cnt_r;
  reg         fs_meta_r;
  reg         fs_sync_r;
  reg         fs_prev_r;
  reg         hs_prev_r;
  reg  [1:0]  stretch_r;
  reg         half_r;
  reg  [1:0]  com_idx_r;
  reg         fetch_busy_r;
  reg  [3:0]  fetch_ptr_r;
  reg         boost_tap;
  reg         hs_tap;
  integer     i;

  wire        fs_rise;
  wire        hs_tick;
  wire        slot_step;
  wire        frame_end;
  wire [3:0]  mem_idx;
  wire        cpu_buf_wr;

  // Last common index for each duty
  function [1:0] last_com;
    input [1:0] duty;
    begin
      case (duty)
        `SLCD_DUTY_QUARTER: last_com = 2'h3;
        `SLCD_DUTY_THIRD:   last_com = 2'h2;
        `SLCD_DUTY_HALF:    last_com = 2'h1;
        default:            last_com = 2'h0;
      endcase
    end
  endfunction

  // Segment level; half bias for 1/2 duty and static drive
  function [1:0] seg_level;
    input       on;
    input       pol;
    input [1:0] duty;
    begin
      if (on)
        seg_level = pol ? `SLCD_LV_V3 : `SLCD_LV_GND;
      else if (duty == `SLCD_DUTY_QUARTER || duty == `SLCD_DUTY_THIRD)
        seg_level = pol ? `SLCD_LV_V1 : `SLCD_LV_V2;
      else
        seg_level = pol ? `SLCD_LV_GND : `SLCD_LV_V3;
    end
  endfunction

  assign lcd_control_reg = {display_enable_bit, voltage_source_select,
                            boost_clock_select, duty_r, frame_rate_select};

  assign mem_hit    = (mem_addr[11:4] == `SLCD_BUF_BASE); // R4
  assign mem_idx    = mem_addr[3:0];
  assign cpu_buf_wr = mem_wr & mem_hit;

  // Control register; stop entry wins over a same-cycle enable write
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      display_enable_bit    <= 1'b0; // R13
      voltage_source_select <= 1'b0;
      boost_clock_select    <= 2'h0;
      duty_r                <= 2'h0;
      frame_rate_select     <= 2'h0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        display_enable_bit    <= ctrl_wdata[`SLCD_EN_BIT];
        voltage_source_select <= ctrl_wdata[`SLCD_VOLTAGE_SOURCE_SELECT_BIT]; // R1
        boost_clock_select    <= ctrl_wdata[`SLCD_VF_HI:`SLCD_VF_LO];
        duty_r                <= ctrl_wdata[`SLCD_DUTY_HI:`SLCD_DUTY_LO];
        frame_rate_select     <= ctrl_wdata[`SLCD_SLF_HI:`SLCD_SLF_LO];
      end
      if (stop_enter)
        display_enable_bit <= 1'b0; // R10
    end
  end

  // Buffer memory has no reset: its contents are undefined until written
  always @(posedge clk)
  begin
    if (cpu_buf_wr)
      shared_data_buffer[mem_idx] <= mem_wdata; // R4
    mem_rdata <= shared_data_buffer[mem_idx];
  end

  // Sub clock pin synchroniser and rising edge
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fs_meta_r <= 1'b0;
      fs_sync_r <= 1'b0;
      fs_prev_r <= 1'b0;
    end
    else
    begin
      fs_meta_r <= sub_clk;
      fs_sync_r <= fs_meta_r;
      fs_prev_r <= fs_sync_r;
    end
  end

  assign fs_rise = fs_sync_r & ~fs_prev_r;

  // Free-running prescalers of both clocks
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fc_cnt_r <= {`SLCD_FC_W{1'b0}};
      fs_cnt_r <= {`SLCD_FS_W{1'b0}};
    end
    else
    begin
      fc_cnt_r <= fc_cnt_r + 1'b1;
      if (fs_rise)
        fs_cnt_r <= fs_cnt_r + 1'b1;
    end
  end

  // Tap selection; code 11 always uses the main clock
  always @*
  begin
    boost_tap = 1'b0;
    hs_tap    = 1'b0;
    case (boost_clock_select) // R2
      2'h0:    boost_tap = use_sub_clock ? fs_cnt_r[`SLCD_BST_FS0] : fc_cnt_r[`SLCD_BST_FC0];
      2'h1:    boost_tap = use_sub_clock ? fs_cnt_r[`SLCD_BST_FS1] : fc_cnt_r[`SLCD_BST_FC1];
      2'h2:    boost_tap = use_sub_clock ? fs_cnt_r[`SLCD_BST_FS2] : fc_cnt_r[`SLCD_BST_FC2];
      default: boost_tap = fc_cnt_r[`SLCD_BST_FC3]; // R14
    endcase
    case (frame_rate_select)
      2'h0:    hs_tap = use_sub_clock ? fs_cnt_r[`SLCD_HS_FS0] : fc_cnt_r[`SLCD_HS_FC0];
      2'h1:    hs_tap = use_sub_clock ? fs_cnt_r[`SLCD_HS_FS1] : fc_cnt_r[`SLCD_HS_FC1];
      2'h2:    hs_tap = fc_cnt_r[`SLCD_HS_FC2];
      default: hs_tap = fc_cnt_r[`SLCD_HS_FC3];
    endcase
  end

  // Booster clock runs only when the internal booster is chosen
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      booster_on <= 1'b0;
      boost_clk  <= 1'b0;
      hs_prev_r  <= 1'b0;
    end
    else
    begin
      booster_on <= voltage_source_select; // R1
      boost_clk  <= voltage_source_select & boost_tap; // R1
      hs_prev_r  <= hs_tap;
    end
  end

  assign hs_tick   = hs_tap & ~hs_prev_r;
  // Static frames hold one common, so each half is stretched to fill it
  assign slot_step = hs_tick &
                     ((duty_r != `SLCD_DUTY_STATIC) || (stretch_r == `SLCD_STATIC_STRETCH));
  assign frame_end = slot_step & half_r & (com_idx_r >= last_com(duty_r));

  // Common scan: each slot has two halves of opposite polarity (no DC)
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stretch_r <= 2'h0;
      half_r    <= 1'b0;
      com_idx_r <= 2'h0;
    end
    else if (hs_tick)
    begin
      stretch_r <= stretch_r + 2'h1;
      if (slot_step)
      begin
        stretch_r <= 2'h0;
        half_r    <= ~half_r;
        if (frame_end)
          com_idx_r <= 2'h0; // R8
        else if (half_r)
          com_idx_r <= com_idx_r + 2'h1;
      end
    end
  end

  // Fetch into the snapshot once per frame; CPU buffer writes take the
  // port first, so a write racing the fetch shows no later than the next frame
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_busy_r <= 1'b1;
      fetch_ptr_r  <= 4'h0;
    end
    else if (fetch_busy_r)
    begin
      if (!cpu_buf_wr) // R15
      begin
        fetch_ptr_r <= fetch_ptr_r + 4'h1;
        if (fetch_ptr_r == `SLCD_BUF_LAST)
          fetch_busy_r <= 1'b0;
      end
    end
    else if (frame_end)
    begin
      fetch_busy_r <= 1'b1; // R5
      fetch_ptr_r  <= 4'h0;
    end
  end

  always @(posedge clk)
  begin
    if (fetch_busy_r && !cpu_buf_wr)
      frame_snap[fetch_ptr_r] <= shared_data_buffer[fetch_ptr_r]; // R5
  end

  // Line levels; blanking and reset put every line at ground
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      segment_line    <= 64'h0; // R11
      common_line     <= 8'h00; // R11
      segment_line_oe <= 32'h0; // R11
    end
    else
    begin
      segment_line_oe <= seg_pin_select;
      if (!display_enable_bit)
      begin
        segment_line <= 64'h0; // R9
        common_line  <= 8'h00; // R9
      end
      else
      begin
        for (i = 0; i < 4; i = i + 1)
        begin
          if (i == com_idx_r)
            common_line[2*i +: 2] <= half_r ? `SLCD_LV_GND : `SLCD_LV_V3;
          else if (i > last_com(duty_r))
            common_line[2*i +: 2] <= `SLCD_LV_GND;
          else if (duty_r == `SLCD_DUTY_HALF)
            common_line[2*i +: 2] <= `SLCD_LV_V1;
          else
            common_line[2*i +: 2] <= half_r ? `SLCD_LV_V2 : `SLCD_LV_V1;
        end
        for (i = 0; i < 32; i = i + 1)
        begin
          // Odd segments read the upper nibble of their byte
          segment_line[2*i +: 2] <= // R6 R7
            seg_level(frame_snap[i/2][(i%2)*4 + com_idx_r], half_r, duty_r);
        end
      end
    end
  end

endmodule // slcd_driver

// ---- tb/slcd_checker.sv ----
/* Port assertions for the segment LCD driver.
   Bound to slcd_driver from the bench top file. */
module slcd_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Control and buffer
  input wire logic        ctrl_wr,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [7:0]  lcd_control_reg,
  input wire logic        stop_enter,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_hit,
  input wire logic [31:0] seg_pin_select,
  // Outputs
  input wire logic        booster_on,
  input wire logic        boost_clk,
  input wire logic [63:0] segment_line,
  input wire logic [7:0]  common_line,
  input wire logic [31:0] segment_line_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  sequence wr_s;
    ctrl_wr && !stop_enter;
  endsequence
  sequence off_s;
    !lcd_control_reg[6] [*2];
  endsequence
  // Async reset, so the lines are already low at any edge in reset
  rst_low_a: assert property (@(posedge clk) !resetn |->
    segment_line == 64'h0 && common_line == 8'h0 && segment_line_oe == 32'h0)
    else $error("lines not low in reset");
  blank_a: assert property (@(posedge clk) disable iff (!resetn)
    !lcd_control_reg[7] |=> segment_line == 64'h0 && common_line == 8'h0)
    else $error("lines driven while blanked");
  ctrl_wr_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_s |=> lcd_control_reg == $past(ctrl_wdata))
    else $error("control write lost");
  ctrl_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !ctrl_wr && !stop_enter |=> $stable(lcd_control_reg))
    else $error("control changed by itself");
  stop_clr_a: assert property (@(posedge clk) disable iff (!resetn)
    stop_enter |=> !lcd_control_reg[7])
    else $error("stop left display on");
  oe_a: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> segment_line_oe == $past(seg_pin_select))
    else $error("pin enable wrong");
  bst_on_a: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> booster_on == $past(lcd_control_reg[6]))
    else $error("booster select not followed");
  bst_clk_a: assert property (@(posedge clk) disable iff (!resetn)
    off_s |-> !boost_clk)
    else $error("boost clock without booster");
  hit_a: assert property (@(posedge clk) disable iff (!resetn)
    mem_hit == (mem_addr[11:4] == 8'hf8))
    else $error("buffer window decode wrong");
endmodule // slcd_checker

// ---- tb/slcd_panel.sv ----
/* Passive panel model: a pixel is lit when its common and segment
   lines sit three levels apart. Assumes clr is pulsed before use. */
module slcd_panel (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic [63:0] segment_line,
  input  wire logic [7:0]  common_line,
  output logic [127:0]     lit
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk)
  begin
    for (int s = 0; s < 32; s++)
      for (int c = 0; c < 4; c++)
        if (clr)
          lit[s*4+c] <= 1'b0;
        else if ({segment_line[2*s+:2], common_line[2*c+:2]} inside {4'h3, 4'hc})
          lit[s*4+c] <= 1'b1;
  end
endmodule // slcd_panel

// ---- tb/slcd_driver_tb.sv ----
/* Bench for the segment LCD driver: control, buffer, booster clock,
   pixel map per duty, blanking, stop and reset. Needs panel and checker. */
module slcd_driver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 1, ctrl_wr = 0, mem_wr = 0, stop_enter = 0, clr = 0;
  // Sub clock pin period in block clocks, off the sampling edge
  localparam int sub_cyc = 8;
  logic sub_clk = 0, use_sub = 0;
  logic [7:0] ctrl_wdata = 8'h00, mem_wdata = 8'h00;
  logic [11:0] mem_addr = 12'h000;
  logic [31:0] seg_pin_select = 32'hffffffff;
  logic [7:0] lcd_control_reg, mem_rdata, common_line;
  logic booster_on, boost_clk, mem_hit;
  logic [63:0] segment_line;
  logic [31:0] segment_line_oe;
  logic [127:0] lit;
  logic [7:0] img [16];
  int miscompares = 0, compares = 0;
  slcd_driver u_dut (.clk(clk), .resetn(resetn), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .lcd_control_reg(lcd_control_reg), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_hit(mem_hit), .stop_enter(stop_enter), .use_sub_clock(use_sub),
    .sub_clk(sub_clk), .seg_pin_select(seg_pin_select), .booster_on(booster_on),
    .boost_clk(boost_clk), .segment_line(segment_line), .common_line(common_line),
    .segment_line_oe(segment_line_oe));
  slcd_panel u_panel (.clk(clk), .clr(clr), .segment_line(segment_line),
    .common_line(common_line), .lit(lit));
  always #50 clk = ~clk;
  always #(sub_cyc * 50) sub_clk = ~sub_clk;
  task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_ctrl(logic [7:0] d);
    ctrl_wr = 1;
    ctrl_wdata = d;
    cyc(1);
    ctrl_wr = 0;
  endtask
  task automatic wr_mem(logic [11:0] a, logic [7:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1;
    cyc(1);
  endtask
  // Whole buffer is written before the first enable, as start-up code must
  task automatic fill(logic [7:0] seed);
    for (int k = 0; k < 16; k++)
    begin
      img[k] = 8'(k * 8'h29) ^ seed;
      wr_mem(12'hf80 + 12'(k), img[k]);
    end
    wr_mem(12'hf90, 8'hee);
    mem_wr = 0;
    chk("hit", mem_hit, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      mem_addr = 12'hf80 + 12'(k);
      cyc(1);
      chk("rdata", mem_rdata, img[k]);
    end
  endtask
  task automatic boost;
    int sh [4] = '{13, 11, 10, 9};
    int shs [4] = '{5, 3, 2, 0};
    int n;
    int want;
    for (int v = 0; v < 7; v++)
    begin
      // Slow-clock passes stop short of code 11
      use_sub = (v > 3);
      wr_ctrl({2'b01, 2'(v % 4), 4'h1});
      chk("ctrl", lcd_control_reg, {2'b01, 2'(v % 4), 4'h1});
      want = (v < 4) ? (1 << sh[v]) : (sub_cyc << shs[v % 4]);
      while (boost_clk) cyc(1);
      while (!boost_clk) cyc(1);
      n = 0;
      do begin cyc(1); n++; end while (boost_clk);
      do begin cyc(1); n++; end while (!boost_clk);
      chk("bperiod", n, want);
      chk("bon", booster_on, 1'b1);
    end
    use_sub = 0;
    wr_ctrl(8'h01);
    cyc(3);
    chk("boff", {booster_on, boost_clk}, 2'b00);
  endtask
  task automatic show(logic [1:0] duty);
    int nc, fr;
    logic [31:0] e, g;
    nc = (duty == 2'h3) ? 1 : 4 - duty;
    fr = ((duty == 2'h3) ? 8 : 2 * nc) * 1024 + 1100;
    wr_ctrl({4'h8, duty, 2'h3});
    cyc(fr);
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(fr);
    for (int c = 0; c < nc; c++)
    begin
      for (int s = 0; s < 32; s++)
      begin
        e[s] = img[s/2][(s%2)*4+c];
        g[s] = lit[s*4+c];
      end
      chk("pixels", g, e);
    end
  endtask
  task automatic stop_blank;
    wr_ctrl(8'h83);
    cyc(3000);
    stop_enter = 1;
    ctrl_wr = 1;
    cyc(1);
    stop_enter = 0;
    ctrl_wr = 0;
    cyc(2);
    chk("stop", lcd_control_reg, 8'h03);
    chk("blank", {segment_line, common_line}, 72'h0);
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(2100);
    chk("dark", lit, 128'h0);
    wr_ctrl(8'h83);
    chk("resume", lcd_control_reg, 8'h83);
  endtask
  // Reset while the panel is driven: lines drop at once, pins float
  task automatic mid_reset;
    cyc(40);
    resetn = 0;
    cyc(1);
    chk("mid", {lcd_control_reg, segment_line, common_line, segment_line_oe}, 112'h0);
    cyc(1);
    resetn = 1;
    cyc(2);
    chk("oe after", segment_line_oe, 32'hffffffff);
    chk("ctrl after", lcd_control_reg, 8'h00);
  endtask
  initial
  begin
    #1 resetn = 0;
    cyc(1);
    chk("reset", {lcd_control_reg, segment_line, common_line, segment_line_oe},
      112'h0);
    cyc(1);
    resetn = 1;
    seg_pin_select = 32'h0f0f00ff;
    cyc(2);
    chk("oe", segment_line_oe, 32'h0f0f00ff);
    seg_pin_select = 32'hffffffff;
    fill(8'h5a);
    boost();
    show(2'h0);
    show(2'h1);
    fill(8'hc3);
    show(2'h2);
    show(2'h3);
    stop_blank();
    mid_reset();
    final_report();
  end
  // Tests need about 85400 cycles
  initial
  begin
    #(97000 * 100);
    miscompares++;
    final_report();
  end
endmodule // slcd_driver_tb
bind slcd_driver slcd_checker u_chk (.clk(clk), .resetn(resetn), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .lcd_control_reg(lcd_control_reg), .stop_enter(stop_enter),
  .mem_addr(mem_addr), .mem_hit(mem_hit), .seg_pin_select(seg_pin_select),
  .booster_on(booster_on), .boost_clk(boost_clk), .segment_line(segment_line),
  .common_line(common_line), .segment_line_oe(segment_line_oe));
